// ### core/pin_select_consts.svh
// Purpose: Constants for the remappable pin select block
// Assumes: Included by bare name
// Notes: Counts are fixed for this build
`ifndef PIN_SELECT_CONSTS_SVH
`define PIN_SELECT_CONSTS_SVH
`define NUM_PINS 16
`define NUM_PERIPH_INPUTS 8
`define NUM_PERIPH_OUTPUTS 15
`define SEL_WIDTH 4
`define NULL_OUTPUT_SEL 4'h0
`define PIN_MAP_LOCK_BIT 13
`define SINGLE_SESSION_BIT 29
`define INPUT_SEL_RESET 4'h0
`define VALID_PIN_MAX 4'hf
`endif

// ### core/pin_select_pkg.sv
// Purpose: Types for the remappable pin select block
// Assumes: Consts header alongside
// Notes: Types only
package pin_select_pkg;
  typedef logic [3:0] selector_type;
  typedef enum logic [1:0] {lock_open, lock_closed, lock_frozen} lock_state_type;
endpackage

// ### core/pin_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: One clock, sync active-low reset
// Notes: First stage is read only by second
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

// ### core/remappable_pin_select.sv
// Purpose: Run-time remapping between digital peripherals and remappable pins
// Assumes: Single clock; unlock logic and analog claims arrive as same-domain qualifiers
// Notes: Selector writes are plain strobes with no error answer
// Notes on behaviour
// - Remappable peripherals have no pin until software selects one.
// - A mapped remappable output overrides other digital functions on its pin.
// - An analog function on a pin always wins over any remappable mapping.
// - Input and output routing use separate selector sets.
// - Each peripheral input has a 4-bit selector naming the pin that feeds it.
// - Each remappable pin has a 4-bit selector naming the peripheral output it carries.
// - Output selector zero is null and all output selectors reset to zero.
// - While locked, selector writes are accepted silently but change nothing.
// - The lock bit sits at bit 13 of the system config register; set blocks writes.
// - Lock bit changes need the system unlock sequence first; otherwise ignored.
// - With the single-session option set, a set lock cannot be cleared.
// - Under that option only a device reset clears the lock.
// - Unprogrammed configuration memory reads the single-session option as set.
// - Only UART, SPI, timer clock, capture, compare and change-notice signals route here.
// - Two-wire bus and analog modules stay on fixed pins outside this matrix.
`timescale 1ns/1ps
`include "pin_select_consts.svh"
module remappable_pin_select
  import pin_select_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin side
  input wire logic [`NUM_PINS-1:0] pin_in,
  input wire logic [`NUM_PINS-1:0] analog_claim,
  input wire logic [`NUM_PINS-1:0] gpio_out,
  input wire logic [`NUM_PINS-1:0] gpio_oe,
  output logic [`NUM_PINS-1:0] pin_out,
  output logic [`NUM_PINS-1:0] pin_oe,
  output logic [`NUM_PINS-1:0] pin_remapped,
  // Peripheral side
  input wire logic [`NUM_PERIPH_OUTPUTS-1:0] periph_out,
  input wire logic [`NUM_PERIPH_OUTPUTS-1:0] periph_oe,
  output logic [`NUM_PERIPH_INPUTS-1:0] periph_in,
  output logic [`NUM_PERIPH_INPUTS-1:0] periph_in_mapped,
  // Selector writes
  input wire logic in_sel_we,
  input wire logic [2:0] in_sel_index,
  input wire logic out_sel_we,
  input wire logic [3:0] out_sel_index,
  input wire logic [3:0] sel_wdata,
  // System config register lock bit
  input wire logic config_we,
  input wire logic [31:0] config_wdata,
  input wire logic unlock_granted,
  input wire logic [31:0] boot_config_word_three,
  input wire logic config_programmed,
  output logic pin_map_lock,
  output logic single_session_lock_option,
  output logic [31:0] system_config_register
);
  selector_type in_sel [`NUM_PERIPH_INPUTS];
  selector_type pin_output_selector [`NUM_PINS];
  logic [`NUM_PERIPH_INPUTS-1:0] in_sel_set;
  logic [`NUM_PINS-1:0] pin_sync_val;
  logic [`NUM_PERIPH_INPUTS-1:0] next_periph_in;
  logic [`NUM_PINS-1:0] next_pin_out;
  logic [`NUM_PINS-1:0] next_pin_oe;
  logic [`NUM_PINS-1:0] next_remapped;
  logic option_now;
  logic lock_write;
  logic next_lock;
  logic [`NUM_PERIPH_INPUTS-1:0] in_sel_hit;
  logic [`NUM_PINS-1:0] out_sel_hit;

  // Pins are foreign to the clock domain
  pin_sync #(.WIDTH(`NUM_PINS)) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(pin_in),
    .sync_out(pin_sync_val)
  );

  // Unprogrammed memory behaves as option set
  assign option_now = !config_programmed || boot_config_word_three[`SINGLE_SESSION_BIT];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      single_session_lock_option <= 1'b1;
    end else begin
      single_session_lock_option <= option_now;
    end
  end

  assign lock_write = config_we && unlock_granted;

  always_comb begin
    next_lock = pin_map_lock;
    if (lock_write) begin
      next_lock = config_wdata[`PIN_MAP_LOCK_BIT];
      // Clearing is refused once frozen; reset is the only way out
      if (pin_map_lock && single_session_lock_option) begin
        next_lock = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_map_lock <= 1'b0;
    end else begin
      pin_map_lock <= next_lock;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      system_config_register <= 32'h0000_0000;
    end else begin
      system_config_register <= 32'h0000_0000 | ({31'h0000_0000, next_lock} << `PIN_MAP_LOCK_BIT);
    end
  end

  // Index decode; a write reaches exactly one selector
  always_comb begin
    in_sel_hit = '0;
    if (in_sel_index == 3'h0) begin
      in_sel_hit[0] = 1'b1;
    end else if (in_sel_index == 3'h1) begin
      in_sel_hit[1] = 1'b1;
    end else if (in_sel_index == 3'h2) begin
      in_sel_hit[2] = 1'b1;
    end else if (in_sel_index == 3'h3) begin
      in_sel_hit[3] = 1'b1;
    end else if (in_sel_index == 3'h4) begin
      in_sel_hit[4] = 1'b1;
    end else if (in_sel_index == 3'h5) begin
      in_sel_hit[5] = 1'b1;
    end else if (in_sel_index == 3'h6) begin
      in_sel_hit[6] = 1'b1;
    end else if (in_sel_index == 3'h7) begin
      in_sel_hit[7] = 1'b1;
    end
  end

  always_comb begin
    out_sel_hit = '0;
    if (out_sel_index == 4'h0) begin
      out_sel_hit[0] = 1'b1;
    end else if (out_sel_index == 4'h1) begin
      out_sel_hit[1] = 1'b1;
    end else if (out_sel_index == 4'h2) begin
      out_sel_hit[2] = 1'b1;
    end else if (out_sel_index == 4'h3) begin
      out_sel_hit[3] = 1'b1;
    end else if (out_sel_index == 4'h4) begin
      out_sel_hit[4] = 1'b1;
    end else if (out_sel_index == 4'h5) begin
      out_sel_hit[5] = 1'b1;
    end else if (out_sel_index == 4'h6) begin
      out_sel_hit[6] = 1'b1;
    end else if (out_sel_index == 4'h7) begin
      out_sel_hit[7] = 1'b1;
    end else if (out_sel_index == 4'h8) begin
      out_sel_hit[8] = 1'b1;
    end else if (out_sel_index == 4'h9) begin
      out_sel_hit[9] = 1'b1;
    end else if (out_sel_index == 4'ha) begin
      out_sel_hit[10] = 1'b1;
    end else if (out_sel_index == 4'hb) begin
      out_sel_hit[11] = 1'b1;
    end else if (out_sel_index == 4'hc) begin
      out_sel_hit[12] = 1'b1;
    end else if (out_sel_index == 4'hd) begin
      out_sel_hit[13] = 1'b1;
    end else if (out_sel_index == 4'he) begin
      out_sel_hit[14] = 1'b1;
    end else if (out_sel_index == 4'hf) begin
      out_sel_hit[15] = 1'b1;
    end
  end

  // Input selectors, one per peripheral input
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < `NUM_PERIPH_INPUTS; i++) begin
        in_sel[i] <= `INPUT_SEL_RESET;
      end
      in_sel_set <= '0;
    end else if (in_sel_we && !pin_map_lock) begin
      for (int i = 0; i < `NUM_PERIPH_INPUTS; i++) begin
        if (in_sel_hit[i]) begin
          in_sel[i] <= sel_wdata;
          in_sel_set[i] <= 1'b1;
        end
      end
    end
  end

  // Output selectors, one per pin
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        pin_output_selector[i] <= `NULL_OUTPUT_SEL;
      end
    end else if (out_sel_we && !pin_map_lock) begin
      for (int i = 0; i < `NUM_PINS; i++) begin
        if (out_sel_hit[i]) begin
          pin_output_selector[i] <= sel_wdata;
        end
      end
    end
  end

  // Route pins to peripheral inputs; an analog pin reads low digitally
  always_comb begin
    for (int i = 0; i < `NUM_PERIPH_INPUTS; i++) begin
      next_periph_in[i] = 1'b0;
      if (in_sel_set[i]) begin
        // Analog owner masks the digital level
        if (in_sel[i] == 4'h0) begin
          next_periph_in[i] = pin_sync_val[0] && !analog_claim[0];
        end else if (in_sel[i] == 4'h1) begin
          next_periph_in[i] = pin_sync_val[1] && !analog_claim[1];
        end else if (in_sel[i] == 4'h2) begin
          next_periph_in[i] = pin_sync_val[2] && !analog_claim[2];
        end else if (in_sel[i] == 4'h3) begin
          next_periph_in[i] = pin_sync_val[3] && !analog_claim[3];
        end else if (in_sel[i] == 4'h4) begin
          next_periph_in[i] = pin_sync_val[4] && !analog_claim[4];
        end else if (in_sel[i] == 4'h5) begin
          next_periph_in[i] = pin_sync_val[5] && !analog_claim[5];
        end else if (in_sel[i] == 4'h6) begin
          next_periph_in[i] = pin_sync_val[6] && !analog_claim[6];
        end else if (in_sel[i] == 4'h7) begin
          next_periph_in[i] = pin_sync_val[7] && !analog_claim[7];
        end else if (in_sel[i] == 4'h8) begin
          next_periph_in[i] = pin_sync_val[8] && !analog_claim[8];
        end else if (in_sel[i] == 4'h9) begin
          next_periph_in[i] = pin_sync_val[9] && !analog_claim[9];
        end else if (in_sel[i] == 4'ha) begin
          next_periph_in[i] = pin_sync_val[10] && !analog_claim[10];
        end else if (in_sel[i] == 4'hb) begin
          next_periph_in[i] = pin_sync_val[11] && !analog_claim[11];
        end else if (in_sel[i] == 4'hc) begin
          next_periph_in[i] = pin_sync_val[12] && !analog_claim[12];
        end else if (in_sel[i] == 4'hd) begin
          next_periph_in[i] = pin_sync_val[13] && !analog_claim[13];
        end else if (in_sel[i] == 4'he) begin
          next_periph_in[i] = pin_sync_val[14] && !analog_claim[14];
        end else if (in_sel[i] == 4'hf) begin
          next_periph_in[i] = pin_sync_val[15] && !analog_claim[15];
        end
      end
    end
  end

  // Route peripheral outputs to pins with remap over GPIO and analog over all
  always_comb begin
    for (int p = 0; p < `NUM_PINS; p++) begin
      next_pin_out[p] = gpio_out[p];
      next_pin_oe[p] = gpio_oe[p];
      next_remapped[p] = 1'b0;
      if (pin_output_selector[p] != `NULL_OUTPUT_SEL) begin
        next_remapped[p] = 1'b1;
      end
      // Code k carries peripheral output k-1; code zero leaves the port drive
      if (pin_output_selector[p] == 4'h1) begin
        next_pin_out[p] = periph_out[0];
        next_pin_oe[p] = periph_oe[0];
      end else if (pin_output_selector[p] == 4'h2) begin
        next_pin_out[p] = periph_out[1];
        next_pin_oe[p] = periph_oe[1];
      end else if (pin_output_selector[p] == 4'h3) begin
        next_pin_out[p] = periph_out[2];
        next_pin_oe[p] = periph_oe[2];
      end else if (pin_output_selector[p] == 4'h4) begin
        next_pin_out[p] = periph_out[3];
        next_pin_oe[p] = periph_oe[3];
      end else if (pin_output_selector[p] == 4'h5) begin
        next_pin_out[p] = periph_out[4];
        next_pin_oe[p] = periph_oe[4];
      end else if (pin_output_selector[p] == 4'h6) begin
        next_pin_out[p] = periph_out[5];
        next_pin_oe[p] = periph_oe[5];
      end else if (pin_output_selector[p] == 4'h7) begin
        next_pin_out[p] = periph_out[6];
        next_pin_oe[p] = periph_oe[6];
      end else if (pin_output_selector[p] == 4'h8) begin
        next_pin_out[p] = periph_out[7];
        next_pin_oe[p] = periph_oe[7];
      end else if (pin_output_selector[p] == 4'h9) begin
        next_pin_out[p] = periph_out[8];
        next_pin_oe[p] = periph_oe[8];
      end else if (pin_output_selector[p] == 4'ha) begin
        next_pin_out[p] = periph_out[9];
        next_pin_oe[p] = periph_oe[9];
      end else if (pin_output_selector[p] == 4'hb) begin
        next_pin_out[p] = periph_out[10];
        next_pin_oe[p] = periph_oe[10];
      end else if (pin_output_selector[p] == 4'hc) begin
        next_pin_out[p] = periph_out[11];
        next_pin_oe[p] = periph_oe[11];
      end else if (pin_output_selector[p] == 4'hd) begin
        next_pin_out[p] = periph_out[12];
        next_pin_oe[p] = periph_oe[12];
      end else if (pin_output_selector[p] == 4'he) begin
        next_pin_out[p] = periph_out[13];
        next_pin_oe[p] = periph_oe[13];
      end else if (pin_output_selector[p] == 4'hf) begin
        next_pin_out[p] = periph_out[14];
        next_pin_oe[p] = periph_oe[14];
      end
      if (analog_claim[p]) begin
        next_pin_out[p] = 1'b0;
        next_pin_oe[p] = 1'b0;
        next_remapped[p] = 1'b0;
      end
    end
  end

  // Registered outputs; matrix carries only digital peripheral signals
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_remapped <= '0;
      periph_in <= '0;
      periph_in_mapped <= '0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_remapped <= next_remapped;
      periph_in <= next_periph_in;
      periph_in_mapped <= in_sel_set;
    end
  end
endmodule

// ### verif/far_side.sv
// Purpose: Peripheral outputs and pad levels seen by the matrix
// Assumes: Pattern is set by the bench between rounds
// Notes: Levels only, peripheral output enables come from the bench
`timescale 1ns/1ps
module far_side (
  input wire logic [31:0] pat,
  output logic [15:0] pin_in,
  output logic [14:0] periph_out
);
  assign pin_in = pat[15:0];
  assign periph_out = pat[30:16];
endmodule

// ### verif/pin_select_checker.sv
// Purpose: Port assertions for remappable_pin_select
// Assumes: One clock, synchronous active-low reset
// Notes: Selector effects reach the pins two edges after the strobe
`timescale 1ns/1ps
module pin_select_checker (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] analog_claim,
  input wire logic [15:0] pin_remapped,
  input wire logic out_sel_we,
  input wire logic config_we,
  input wire logic [31:0] config_wdata,
  input wire logic unlock_granted,
  input wire logic pin_map_lock,
  input wire logic single_session_lock_option,
  input wire logic [31:0] system_config_register
);
  wire granted = config_we && unlock_granted;
  wire frozen = pin_map_lock && single_session_lock_option;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_lock_hold: assert property (!granted |=> $stable(pin_map_lock))
    else $error("lock moved without unlock");
  a_lock_set: assert property (granted && config_wdata[13] |=> pin_map_lock)
    else $error("lock not set");
  a_lock_clear: assert property (granted && !config_wdata[13] && !frozen |=> !pin_map_lock)
    else $error("lock not cleared");
  a_lock_sticky: assert property (frozen |=> pin_map_lock)
    else $error("frozen lock cleared");
  a_cfg_mirror: assert property (system_config_register[13] == pin_map_lock)
    else $error("config bit differs from lock");
  a_analog_wins: assert property ((analog_claim & $past(analog_claim) & pin_remapped) == 0)
    else $error("analog pin still remapped");
  a_locked_freeze: assert property (out_sel_we && pin_map_lock ##1 !out_sel_we
    && $stable(analog_claim) |=> $stable(pin_remapped)) else $error("locked write took effect");
  a_remap_steady: assert property (!out_sel_we ##1 !out_sel_we && $stable(analog_claim)
    |=> $stable(pin_remapped)) else $error("remap changed without a write");
  cover property (granted && frozen && !config_wdata[13]);
  cover property (out_sel_we && pin_map_lock);
  cover property (config_we && !unlock_granted);
endmodule
bind remappable_pin_select pin_select_checker checker_i (.sys_clk, .nrst, .analog_claim,
  .pin_remapped, .out_sel_we, .config_we, .config_wdata, .unlock_granted, .pin_map_lock,
  .single_session_lock_option, .system_config_register);

// ### verif/tb.sv
// Purpose: Self-checking bench for remappable_pin_select
// Assumes: Far side levels come from far_side
// Notes: Model selectors are ints, -1 means an input selector never written, output ones start at 0
`timescale 1ns/1ps
module tb;
  logic sys_clk = 0, nrst = 0, isw = 0, osw = 0, cw = 0, ug = 0, prog = 0, lock, opt, lk, oo;
  logic [3:0] idx = 0, wd = 0;
  logic [15:0] an = 0, gpo = 16'h5a5a, gpe = 16'hff00, po, pe, rm, pin;
  logic [14:0] pout, poe = 0;
  logic [7:0] pi, pim;
  logic [31:0] cd = 0, boot = 0, pat = 0, scr, lf = 32'h0001_34a4;
  int miscompares = 0, n_compared = 0, os[16], is[8];
  always #4 sys_clk = ~sys_clk;
  far_side ps (.pat(pat), .pin_in(pin), .periph_out(pout));
  remappable_pin_select dut (.sys_clk(sys_clk), .nrst(nrst), .pin_in(pin), .analog_claim(an),
    .gpio_out(gpo), .gpio_oe(gpe), .pin_out(po), .pin_oe(pe), .pin_remapped(rm),
    .periph_out(pout), .periph_oe(poe), .periph_in(pi), .periph_in_mapped(pim),
    .in_sel_we(isw), .in_sel_index(idx[2:0]), .out_sel_we(osw), .out_sel_index(idx),
    .sel_wdata(wd), .config_we(cw), .config_wdata(cd), .unlock_granted(ug),
    .boot_config_word_three(boot), .config_programmed(prog), .pin_map_lock(lk),
    .single_session_lock_option(oo), .system_config_register(scr));
  function automatic logic [31:0] nxt(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cfg(logic g, logic b);
    ug = g;
    cd = 32'(b) << 13;
    cw = 1;
    tick(1);
    cw = 0;
    if (g && (b || !lock || !opt)) lock = b;
    chk(scr, 32'(lock) << 13);
    tick(1);
  endtask
  task automatic rst(logic p, logic b);
    nrst = 0;
    prog = p;
    boot = 32'(b) << 29;
    tick(8);
    nrst = 1;
    os = '{default: 0};
    is = '{default: -1};
    lock = 0;
    opt = !p || b;
    tick(1);
    chk({oo, lk, rm, pim}, {opt, 1'b0, 24'h0});
  endtask
  task automatic round();
    for (int k = 0; k < 24; k++) begin
      lf = nxt(lf);
      osw = k < 16;
      isw = k >= 16;
      idx = 4'(k);
      wd = lf[3:0];
      if (!lock && k < 16) os[k] = lf[3:0];
      if (!lock && k >= 16) is[k - 16] = lf[3:0];
      tick(1);
    end
    osw = 0;
    isw = 0;
    pat = nxt(lf);
    lf = nxt(pat);
    an = lf[15:0] & lf[31:16];
    poe = pat[14:0] ^ lf[30:16];
    tick(6);
    for (int p = 0; p < 16; p++) begin
      if (an[p]) chk({rm[p], pe[p], po[p]}, 3'b000);
      else if (os[p] == 0) chk({rm[p], pe[p], po[p]}, {1'b0, gpe[p], gpo[p]});
      else chk({rm[p], pe[p], po[p]}, {1'b1, poe[os[p] - 1], pout[os[p] - 1]});
    end
    for (int i = 0; i < 8; i++) begin
      if (is[i] < 0) chk({pim[i], pi[i]}, 2'b00);
      else chk({pim[i], pi[i]}, {1'b1, !an[is[i]] & pin[is[i]]});
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is under a thousand cycles, so this only trips on a hang
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
  initial begin
    rst(1'b0, 1'b0);
    round();
    cfg(1'b0, 1'b1);
    chk(lk, 0);
    cfg(1'b1, 1'b1);
    chk({lk, scr[13]}, 2'b11);
    round();
    cfg(1'b1, 1'b0);
    chk(lk, 1);
    rst(1'b1, 1'b0);
    cfg(1'b1, 1'b1);
    cfg(1'b1, 1'b0);
    chk(lk, 0);
    round();
    rst(1'b1, 1'b1);
    wrap_up();
  end
endmodule
